// ---- tmoe_params.svh ----
// Constants for the timer output and edge control block.
// Assumes a single 10 MHz clock and a plain strobe register port.
//
// What this block does
// RL1: A mode bit selects transmit or demodulation; shared fields follow it.
// RL2: Transmit: two-bit field merges both timer outputs by AND, OR, NOR, NAND.
// RL3: Demodulation: same field picks rising, falling or both edges.
// RL4: Transmit submode picks alternating or normal; normal ends alternating at once.
// RL5: Submode 10 forces long output low, 11 forces it high, at once.
// RL6: Demodulation: submode sets the glitch filter width.
// RL7: Short output takes its initial-level bit when counting starts.
// RL8: Short output is inverse of its initial bit while disabled.
// RL9: Long output takes its initial bit at start, unless forced.
// RL10: Long output is inverse of initial bit while disabled and unforced.
// RL11: Demodulation rising edge sets a flag; writing one clears it.
// RL12: Demodulation falling edge sets a flag; writing one clears it.
// RL13: Software keeps initial-level bits steady while counters run.
// RL14: Combined enable drives the combined pin with the selected function.
// RL15: Alternating mode hands the run enable between the timers in turn.
`ifndef TMOE_PARAMS_SVH
`define TMOE_PARAMS_SVH

// ***************************************************
// Register offsets
// ***************************************************
`define TMOE_OFS_EDGE_CTRL   8'h01
`define TMOE_OFS_PAIR_CTRL3  8'h03
`define TMOE_OFS_RUN_CTRL    8'h10
`define TMOE_OFS_IRQ_STAT    8'h11
`define TMOE_OFS_IRQ_MASK    8'h12

// ***************************************************
// Field positions of the edge control register
// ***************************************************
`define TMOE_BIT_MODE        7
`define TMOE_BIT_COMB_EN     6
`define TMOE_BIT_SEL_HI      5
`define TMOE_BIT_SEL_LO      4
`define TMOE_BIT_SUB_HI      3
`define TMOE_BIT_SUB_LO      2
`define TMOE_BIT_SHORT_INIT  1
`define TMOE_BIT_LONG_INIT   0

// Run control fields
`define TMOE_BIT_SHORT_RUN   0
`define TMOE_BIT_LONG_RUN    1

// Status and mask fields
`define TMOE_BIT_IRQ_RISE    0
`define TMOE_BIT_IRQ_FALL    1

// ***************************************************
// Reset values
// ***************************************************
`define TMOE_RST_EDGE_CTRL   8'h00
`define TMOE_RST_RUN_CTRL    2'h0
`define TMOE_RST_IRQ_MASK    2'h0
`define TMOE_RST_PAIR_LOW    5'h1F

// Glitch widths in cycles for each filter setting
`define TMOE_GLITCH_W0       4'h0
`define TMOE_GLITCH_W1       4'h2
`define TMOE_GLITCH_W2       4'h4
`define TMOE_GLITCH_W3       4'h8

`endif

// ---- tmoe_pkg.sv ----
// Types for the timer output and edge control block.
// Shared by the top and the glitch filter.
package tmoe_pkg;
   typedef enum logic [1:0] {
      TMOE_SUB_NORMAL = 2'h0,
      TMOE_SUB_ALT    = 2'h1,
      TMOE_SUB_FORCE0 = 2'h2,
      TMOE_SUB_FORCE1 = 2'h3
   } tmoe_sub_t;

   typedef enum logic [1:0] {
      TMOE_FN_AND  = 2'h0,
      TMOE_FN_OR   = 2'h1,
      TMOE_FN_NOR  = 2'h2,
      TMOE_FN_NAND = 2'h3
   } tmoe_fn_t;

   typedef enum logic [1:0] {
      TMOE_ALT_SHORT = 2'b01,
      TMOE_ALT_LONG  = 2'b10
   } tmoe_alt_t;
endpackage

// ---- tmoe_glitch_filter.sv ----
// Glitch filter: passes a level only after it has held for more than the width.
// Assumes the input is already synchronised to ref_clk_i.
`timescale 1ns/1ps
`include "tmoe_params.svh"
module tmoe_glitch_filter
   import tmoe_pkg::*;
(
   input  wire logic       ref_clk_i, // System clock
   input  wire logic       srst_i,    // Synchronous reset
   input  wire logic       din_i,     // Synchronised level
   input  wire logic [1:0] width_i,   // Filter width setting
   output logic            dout_o     // Filtered level
);
   logic [3:0] cnt;
   logic [3:0] next_cnt;
   logic       dout;
   logic       next_dout;
   logic [3:0] limit;

   always_comb begin
      unique case (width_i)
         2'h0: limit = `TMOE_GLITCH_W0;
         2'h1: limit = `TMOE_GLITCH_W1;
         2'h2: limit = `TMOE_GLITCH_W2;
         2'h3: limit = `TMOE_GLITCH_W3;
      endcase
   end

   // A pulse no longer than the limit never reaches the output
   always_comb begin
      next_cnt  = 4'h0;
      next_dout = dout;
      if (din_i != dout) begin
         if (cnt >= limit) begin
            next_dout = din_i;
         end else begin
            next_cnt = cnt + 4'h1;
         end
      end
   end

   always_ff @(posedge ref_clk_i) begin
      if (srst_i) begin
         cnt  <= 4'h0;
         dout <= 1'b0;
      end else begin
         cnt  <= next_cnt;
         dout <= next_dout;
      end
   end

   assign dout_o = dout;
endmodule

// ---- tmoe_top.sv ----
// Output combining and edge detect control for an 8-bit and a 16-bit timer.
// Assumes the counting datapath supplies terminal-count pulses and follows the run enables driven from here.
//
// Our own choice: the plain strobed port.
`timescale 1ns/1ps
`include "tmoe_params.svh"
module tmoe_top
   import tmoe_pkg::*;
(
   input  wire logic       ref_clk_i,       // 10 MHz system clock
   input  wire logic       srst_i,          // Synchronous reset, active high
   input  wire logic [7:0] addr_i,          // Register address
   input  wire logic [7:0] wdata_i,         // Write data
   input  wire logic       wr_i,            // Write strobe
   input  wire logic       rd_i,            // Read strobe
   input  wire logic       short_tc_i,      // Short timer terminal count pulse
   input  wire logic       long_tc_i,       // Long timer terminal count pulse
   input  wire logic       wave_i,          // Waveform input pin
   output logic [7:0]      rdata_o,         // Read data, cycle after read strobe
   output logic            short_run_o,     // Short timer enable
   output logic            long_run_o,      // Long timer enable
   output logic            short_out_o,     // Short timer output
   output logic            long_out_o,      // Long timer output
   output logic            combined_pin_o,  // Combined output pin
   output logic            rise_pulse_o,    // Detected rising edge
   output logic            fall_pulse_o,    // Detected falling edge
   output logic            irq_o            // Level interrupt
);
   // ***************************************************
   // Register state
   // ***************************************************
   logic [7:0] edge_ctrl;
   logic [7:0] next_edge_ctrl;
   logic [1:0] run_ctrl;
   logic [1:0] next_run_ctrl;
   logic [1:0] irq_stat;
   logic [1:0] next_irq_stat;
   logic [1:0] irq_mask;
   logic [1:0] next_irq_mask;
   logic [7:0] rdata;
   logic [7:0] next_rdata;
   logic       irq;
   logic       next_irq;

   // ***************************************************
   // Output and edge state
   // ***************************************************
   logic       short_out;
   logic       next_short_out;
   logic       long_out;
   logic       next_long_out;
   logic       comb_pin;
   logic       next_comb_pin;
   logic       rise_p;
   logic       next_rise_p;
   logic       fall_p;
   logic       next_fall_p;
   tmoe_alt_t  alt_turn;
   tmoe_alt_t  next_alt_turn;
   logic       filt_q;
   logic [2:0] sync_q;
   logic       sync_lvl;
   logic       next_sync_lvl;
   logic       filt;

   logic       demod;
   tmoe_sub_t  sub;
   tmoe_fn_t   fn;
   logic       wr_edge;
   logic       wr_run;
   logic       short_start;
   logic       long_start;
   logic       rise_det;
   logic       fall_det;

   function automatic logic merge(input tmoe_fn_t f, input logic a, input logic b);
      unique case (f)
         TMOE_FN_AND:  merge = a & b;
         TMOE_FN_OR:   merge = a | b;
         TMOE_FN_NOR:  merge = ~(a | b);
         TMOE_FN_NAND: merge = ~(a & b);
      endcase
   endfunction

   function automatic logic hit(input logic [7:0] a, input logic [7:0] ofs);
      hit = (a == ofs);
   endfunction

   assign demod   = edge_ctrl[`TMOE_BIT_MODE]; // [RL1]
   assign sub     = tmoe_sub_t'(edge_ctrl[`TMOE_BIT_SUB_HI:`TMOE_BIT_SUB_LO]);
   assign fn      = tmoe_fn_t'(edge_ctrl[`TMOE_BIT_SEL_HI:`TMOE_BIT_SEL_LO]);
   assign wr_edge = wr_i & hit(addr_i, `TMOE_OFS_EDGE_CTRL);
   assign wr_run  = wr_i & hit(addr_i, `TMOE_OFS_RUN_CTRL);

   // ***************************************************
   // Input synchroniser, glitch filter and edge detect
   // ***************************************************
   // A pin change counts once the second and third stages agree
   always_comb begin
      next_sync_lvl = sync_lvl;
      if (sync_q[1] == sync_q[2]) begin
         next_sync_lvl = sync_q[2];
      end
   end

   always_ff @(posedge ref_clk_i) begin
      if (srst_i) begin
         sync_q   <= 3'h0;
         sync_lvl <= 1'b0;
         filt_q   <= 1'b0;
      end else begin
         sync_q   <= {sync_q[1:0], wave_i};
         sync_lvl <= next_sync_lvl;
         filt_q   <= filt;
      end
   end

   tmoe_glitch_filter u_filter (
      .ref_clk_i (ref_clk_i),
      .srst_i    (srst_i),
      .din_i     (sync_lvl),
      .width_i   (edge_ctrl[`TMOE_BIT_SUB_HI:`TMOE_BIT_SUB_LO]), // [RL6]
      .dout_o    (filt)
   );

   // Field 00 is falling only, 01 rising only, 1x both
   assign rise_det = demod & filt & ~filt_q & (fn != TMOE_FN_AND); // [RL3]
   assign fall_det = demod & ~filt & filt_q & (fn != TMOE_FN_OR);  // [RL3]

   // ***************************************************
   // Run enables and alternating hand-over
   // ***************************************************
   always_comb begin
      next_run_ctrl = run_ctrl;
      next_alt_turn = alt_turn;
      if (wr_run) begin
         next_run_ctrl = wdata_i[1:0];
         next_alt_turn = wdata_i[`TMOE_BIT_LONG_RUN] & ~wdata_i[`TMOE_BIT_SHORT_RUN]
                         ? TMOE_ALT_LONG : TMOE_ALT_SHORT;
      end else if (!demod && sub == TMOE_SUB_ALT && (run_ctrl != 2'h0)) begin
         // Only one timer runs; its terminal count passes the turn on
         unique case (alt_turn)
            TMOE_ALT_SHORT: begin
               next_run_ctrl = 2'b01;
               if (short_tc_i) begin
                  next_run_ctrl = 2'b10; // [RL15]
                  next_alt_turn = TMOE_ALT_LONG;
               end
            end
            TMOE_ALT_LONG: begin
               next_run_ctrl = 2'b10;
               if (long_tc_i) begin
                  next_run_ctrl = 2'b01; // [RL15]
                  next_alt_turn = TMOE_ALT_SHORT;
               end
            end
            default: begin
               next_alt_turn = TMOE_ALT_SHORT;
            end
         endcase
      end
   end

   assign short_start = next_run_ctrl[`TMOE_BIT_SHORT_RUN] & ~run_ctrl[`TMOE_BIT_SHORT_RUN];
   assign long_start  = next_run_ctrl[`TMOE_BIT_LONG_RUN] & ~run_ctrl[`TMOE_BIT_LONG_RUN];

   // ***************************************************
   // Control register, flags and interrupt
   // ***************************************************
   always_comb begin
      next_edge_ctrl = edge_ctrl;
      if (wr_edge) begin
         next_edge_ctrl = wdata_i;
         if (wdata_i[`TMOE_BIT_MODE]) begin
            // Flag bits are write-one-to-clear in demodulation
            next_edge_ctrl[`TMOE_BIT_SHORT_INIT] = edge_ctrl[`TMOE_BIT_SHORT_INIT]
                                                 & ~wdata_i[`TMOE_BIT_SHORT_INIT]; // [RL11]
            next_edge_ctrl[`TMOE_BIT_LONG_INIT]  = edge_ctrl[`TMOE_BIT_LONG_INIT]
                                                 & ~wdata_i[`TMOE_BIT_LONG_INIT];  // [RL12]
         end
      end
      // Set wins over a same-cycle clear
      if (rise_det) begin
         next_edge_ctrl[`TMOE_BIT_SHORT_INIT] = 1'b1; // [RL11]
      end
      if (fall_det) begin
         next_edge_ctrl[`TMOE_BIT_LONG_INIT] = 1'b1;  // [RL12]
      end
   end

   always_comb begin
      next_irq_mask = irq_mask;
      next_irq_stat = irq_stat;
      if (wr_i && hit(addr_i, `TMOE_OFS_IRQ_MASK)) begin
         next_irq_mask = wdata_i[1:0];
      end
      if (rd_i && hit(addr_i, `TMOE_OFS_IRQ_STAT)) begin
         next_irq_stat = 2'h0;
      end
      next_irq_stat[`TMOE_BIT_IRQ_RISE] = next_irq_stat[`TMOE_BIT_IRQ_RISE] | rise_det;
      next_irq_stat[`TMOE_BIT_IRQ_FALL] = next_irq_stat[`TMOE_BIT_IRQ_FALL] | fall_det;
      next_irq = |(next_irq_stat & next_irq_mask);
   end

   always_comb begin
      next_rdata = 8'h00;
      if (rd_i) begin
         unique case (1'b1)
            hit(addr_i, `TMOE_OFS_EDGE_CTRL):  next_rdata = edge_ctrl;
            hit(addr_i, `TMOE_OFS_PAIR_CTRL3): next_rdata = {3'h0, `TMOE_RST_PAIR_LOW};
            hit(addr_i, `TMOE_OFS_RUN_CTRL):   next_rdata = {6'h00, run_ctrl};
            hit(addr_i, `TMOE_OFS_IRQ_STAT):   next_rdata = {6'h00, irq_stat};
            hit(addr_i, `TMOE_OFS_IRQ_MASK):   next_rdata = {6'h00, irq_mask};
            default:                           next_rdata = 8'h00;
         endcase
      end
   end

   // ***************************************************
   // Timer outputs and combined pin
   // ***************************************************
   // Initial-level bits are trusted steady while running; no resync on change [RL13]
   always_comb begin
      next_short_out = short_out;
      next_long_out  = long_out;
      if (!demod) begin
         if (!next_run_ctrl[`TMOE_BIT_SHORT_RUN]) begin
            next_short_out = ~edge_ctrl[`TMOE_BIT_SHORT_INIT]; // [RL8]
         end else if (short_start) begin
            next_short_out = edge_ctrl[`TMOE_BIT_SHORT_INIT];  // [RL7]
         end else if (short_tc_i) begin
            next_short_out = ~short_out;
         end
         if (sub == TMOE_SUB_FORCE0) begin
            next_long_out = 1'b0; // [RL5]
         end else if (sub == TMOE_SUB_FORCE1) begin
            next_long_out = 1'b1; // [RL5]
         end else if (!next_run_ctrl[`TMOE_BIT_LONG_RUN]) begin
            next_long_out = ~edge_ctrl[`TMOE_BIT_LONG_INIT]; // [RL10]
         end else if (long_start) begin
            next_long_out = edge_ctrl[`TMOE_BIT_LONG_INIT];  // [RL9]
         end else if (long_tc_i) begin
            next_long_out = ~long_out;
         end
      end
      next_comb_pin = 1'b0;
      if (edge_ctrl[`TMOE_BIT_COMB_EN]) begin
         next_comb_pin = merge(fn, next_short_out, next_long_out); // [RL2] [RL14]
      end
      next_rise_p = rise_det;
      next_fall_p = fall_det;
   end

   // ***************************************************
   // Registers
   // ***************************************************
   // Writing normal submode reaches the run logic next cycle, ending alternation [RL4]
   always_ff @(posedge ref_clk_i) begin
      if (srst_i) begin
         edge_ctrl <= `TMOE_RST_EDGE_CTRL;
         run_ctrl  <= `TMOE_RST_RUN_CTRL;
         alt_turn  <= TMOE_ALT_SHORT;
         irq_stat  <= 2'h0;
         irq_mask  <= `TMOE_RST_IRQ_MASK;
         irq       <= 1'b0;
         rdata     <= 8'h00;
         short_out <= 1'b1;
         long_out  <= 1'b1;
         comb_pin  <= 1'b0;
         rise_p    <= 1'b0;
         fall_p    <= 1'b0;
      end else begin
         edge_ctrl <= next_edge_ctrl;
         run_ctrl  <= next_run_ctrl;
         alt_turn  <= next_alt_turn;
         irq_stat  <= next_irq_stat;
         irq_mask  <= next_irq_mask;
         irq       <= next_irq;
         rdata     <= next_rdata;
         short_out <= next_short_out;
         long_out  <= next_long_out;
         comb_pin  <= next_comb_pin;
         rise_p    <= next_rise_p;
         fall_p    <= next_fall_p;
      end
   end

   assign rdata_o        = rdata;
   assign short_run_o    = run_ctrl[`TMOE_BIT_SHORT_RUN];
   assign long_run_o     = run_ctrl[`TMOE_BIT_LONG_RUN];
   assign short_out_o    = short_out;
   assign long_out_o     = long_out;
   assign combined_pin_o = comb_pin;
   assign rise_pulse_o   = rise_p;
   assign fall_pulse_o   = fall_p;
   assign irq_o          = irq;
endmodule

// ---- tmoe_top_sva.sv ----
// Concurrent checks on the ports of the timer output and edge control top.
// Assumes single clock domain; shadows the edge control register from bus writes.
`timescale 1ns/1ps
module tmoe_top_sva
   import tmoe_pkg::*;
(
   input wire logic       ref_clk_i,      // System clock
   input wire logic       srst_i,         // Synchronous reset
   input wire logic [7:0] addr_i,         // Register address
   input wire logic [7:0] wdata_i,        // Write data
   input wire logic       wr_i,           // Write strobe
   input wire logic       rd_i,           // Read strobe
   input wire logic       short_tc_i,     // Short terminal count
   input wire logic       long_tc_i,      // Long terminal count
   input wire logic       wave_i,         // Waveform pin
   input wire logic [7:0] rdata_o,        // Read data
   input wire logic       short_run_o,    // Short enable
   input wire logic       long_run_o,     // Long enable
   input wire logic       short_out_o,    // Short output
   input wire logic       long_out_o,     // Long output
   input wire logic       combined_pin_o, // Combined pin
   input wire logic       rise_pulse_o,   // Rising pulse
   input wire logic       fall_pulse_o,   // Falling pulse
   input wire logic       irq_o           // Interrupt
);
   // ****
   // Shadow state: quiet counter masks the settling cycles after control writes
   // ****
   logic [7:2] sh_ctrl, next_sh_ctrl;
   logic [1:0] sh_init, next_sh_init;
   logic [1:0] qcnt, next_qcnt;
   logic       comb_exp;
   logic       ctrl_wr;
   logic       quiet_tx;
   assign ctrl_wr = wr_i && (addr_i == 8'h01);
   assign quiet_tx = (qcnt == 2'h3) && !sh_ctrl[7];
   always_comb begin
      next_sh_ctrl = ctrl_wr ? wdata_i[7:2] : sh_ctrl;
      next_sh_init = (ctrl_wr && !wdata_i[7]) ? wdata_i[1:0] : sh_init;
      next_qcnt = (qcnt == 2'h3) ? qcnt : qcnt + 2'h1;
      if (ctrl_wr || (wr_i && addr_i == 8'h10)) begin
         next_qcnt = 2'h0;
      end
      case (sh_ctrl[5:4])
         2'h0: comb_exp = short_out_o & long_out_o;
         2'h1: comb_exp = short_out_o | long_out_o;
         2'h2: comb_exp = ~(short_out_o | long_out_o);
         default: comb_exp = ~(short_out_o & long_out_o);
      endcase
   end
   always_ff @(posedge ref_clk_i) begin
      if (srst_i) begin
         sh_ctrl <= 6'h00;
         sh_init <= 2'h0;
         qcnt <= 2'h0;
      end else begin
         sh_ctrl <= next_sh_ctrl;
         sh_init <= next_sh_init;
         qcnt <= next_qcnt;
      end
   end
   default clocking cb @(posedge ref_clk_i); endclocking
   default disable iff (srst_i);
   sequence s_force_wr(logic [1:0] code);
      ctrl_wr && !wdata_i[7] && wdata_i[3:2] == code;
   endsequence
   sequence s_short_turn_end(logic [1:0] sub);
      quiet_tx && sh_ctrl[3:2] == sub && short_run_o && short_tc_i && !long_run_o;
   endsequence
   a_comb_pin_func: assert property (quiet_tx |-> combined_pin_o == (sh_ctrl[6] && comb_exp))
      else $error("combined pin mismatch");
   a_short_idle_lvl: assert property (quiet_tx && sh_ctrl[3:2] == 2'h0 && !short_run_o |-> short_out_o == !sh_init[1])
      else $error("short idle level");
   a_long_idle_lvl: assert property (quiet_tx && sh_ctrl[3:2] == 2'h0 && !long_run_o |-> long_out_o == !sh_init[0])
      else $error("long idle level");
   a_short_start_lvl: assert property ($rose(short_run_o) && !sh_ctrl[7] && sh_ctrl[3:2] == 2'h0
      |-> ##[0:1] short_out_o == sh_init[1]) else $error("short start level");
   a_long_start_lvl: assert property ($rose(long_run_o) && !sh_ctrl[7] && sh_ctrl[3:2] == 2'h0
      |-> ##[0:1] long_out_o == sh_init[0]) else $error("long start level");
   a_force_low_now: assert property (s_force_wr(2'h2) |-> ##[1:2] !long_out_o)
      else $error("long output not forced low");
   a_force_high_now: assert property (s_force_wr(2'h3) |-> ##[1:2] long_out_o)
      else $error("long output not forced high");
   a_alt_turn_pass: assert property (s_short_turn_end(2'h1) |-> ##[1:2] (long_run_o && !short_run_o))
      else $error("alternating turn not passed");
   a_normal_no_pass: assert property (s_short_turn_end(2'h0) |=> short_run_o && !long_run_o)
      else $error("normal mode passed turn");
   a_tx_no_edge: assert property (quiet_tx |-> !rise_pulse_o && !fall_pulse_o)
      else $error("edge pulse in transmit");
   a_rise_sel_ok: assert property (rise_pulse_o |-> sh_ctrl[7] && sh_ctrl[5:4] != 2'h0)
      else $error("rising pulse not selected");
   a_fall_sel_ok: assert property (fall_pulse_o |-> sh_ctrl[7] && sh_ctrl[5:4] != 2'h1)
      else $error("falling pulse not selected");
   a_rdata_idle_zero: assert property (!rd_i |=> rdata_o == 8'h00)
      else $error("read data outside read cycle");
   a_pair_reads_ones: assert property (rd_i && addr_i == 8'h03 |=> rdata_o == 8'h1F)
      else $error("reserved bits not ones");
endmodule
bind tmoe_top tmoe_top_sva tmoe_top_sva_inst (
   .ref_clk_i(ref_clk_i), .srst_i(srst_i), .addr_i(addr_i), .wdata_i(wdata_i), .wr_i(wr_i), .rd_i(rd_i),
   .short_tc_i(short_tc_i), .long_tc_i(long_tc_i), .wave_i(wave_i), .rdata_o(rdata_o),
   .short_run_o(short_run_o), .long_run_o(long_run_o), .short_out_o(short_out_o), .long_out_o(long_out_o),
   .combined_pin_o(combined_pin_o), .rise_pulse_o(rise_pulse_o), .fall_pulse_o(fall_pulse_o), .irq_o(irq_o)
);

// ---- tmoe_far_model.sv ----
// Far side model: waveform input line and timer counting datapath pulses.
// Assumes tasks are called from the bench; every change lands just after a rising edge.
`timescale 1ns/1ps
module tmoe_far_model (
   input  wire logic ref_clk_i,  // System clock
   output logic      wave_o,     // Waveform line level
   output logic      short_tc_o, // Short terminal count pulse
   output logic      long_tc_o   // Long terminal count pulse
);
   initial begin
      wave_o = 1'b0;
      short_tc_o = 1'b0;
      long_tc_o = 1'b0;
   end
   // One-cycle pulse, as the counters would give at terminal count
   task automatic pulse_tc(input logic long_sel);
      @(posedge ref_clk_i);
      if (long_sel) long_tc_o <= 1'b1;
      else short_tc_o <= 1'b1;
      @(posedge ref_clk_i);
      short_tc_o <= 1'b0;
      long_tc_o <= 1'b0;
   endtask
   task automatic drive_wave(input logic lvl, input int cycles);
      @(posedge ref_clk_i);
      wave_o <= lvl;
      repeat (cycles) @(posedge ref_clk_i);
   endtask
endmodule

// ---- tb.sv ----
// Self-checking bench for the timer output and edge control top.
// Assumes a 10 MHz clock and the far side model for wave and terminal counts.
`timescale 1ns/1ps
module tb;
   import tmoe_pkg::*;
   logic       ref_clk_i, srst_i, wr_i, rd_i, short_tc, long_tc, wave;
   logic [7:0] addr_i, wdata_i, rdata_o, rv;
   logic       short_run_o, long_run_o, short_out_o, long_out_o, combined_pin_o, rise_pulse_o, fall_pulse_o, irq_o;
   logic       e;
   int         miscompares, n_checks, n_rise, n_fall;
   tmoe_top tmoe_top_inst (.ref_clk_i(ref_clk_i), .srst_i(srst_i), .addr_i(addr_i), .wdata_i(wdata_i),
      .wr_i(wr_i), .rd_i(rd_i), .short_tc_i(short_tc), .long_tc_i(long_tc), .wave_i(wave), .rdata_o(rdata_o),
      .short_run_o(short_run_o), .long_run_o(long_run_o), .short_out_o(short_out_o), .long_out_o(long_out_o),
      .combined_pin_o(combined_pin_o), .rise_pulse_o(rise_pulse_o), .fall_pulse_o(fall_pulse_o), .irq_o(irq_o));
   tmoe_far_model tmoe_far_model_inst (.ref_clk_i(ref_clk_i), .wave_o(wave), .short_tc_o(short_tc),
      .long_tc_o(long_tc));
   initial begin
      ref_clk_i = 1'b0;
      forever #50 ref_clk_i = ~ref_clk_i;
   end
   always @(posedge ref_clk_i) begin
      if (rise_pulse_o === 1'b1) n_rise++;
      if (fall_pulse_o === 1'b1) n_fall++;
   end
   task automatic print_verdict;
      $display("comparisons %0d mismatches %0d", n_checks, miscompares);
      if (miscompares == 0 && n_checks > 0) $display("All checks passed");
      else $display("Checks failed");
      $finish;
   endtask
   task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
      n_checks++;
      if (seen !== exp) begin
         miscompares++;
         $display("wrong value at %0t: got %h expected %h", $time, seen, exp);
      end
   endtask
   task automatic wr(input logic [7:0] a, input logic [7:0] d);
      @(posedge ref_clk_i);
      wr_i <= 1'b1;
      addr_i <= a;
      wdata_i <= d;
      @(posedge ref_clk_i);
      wr_i <= 1'b0;
   endtask
   task automatic chk_rd(input logic [7:0] a, input logic [7:0] exp);
      @(posedge ref_clk_i);
      rd_i <= 1'b1;
      addr_i <= a;
      @(posedge ref_clk_i);
      rd_i <= 1'b0;
      @(negedge ref_clk_i);
      chk(rdata_o, exp);
   endtask
   task automatic settle;
      repeat (3) @(posedge ref_clk_i);
      @(negedge ref_clk_i);
   endtask
   initial begin
      repeat (20000) @(posedge ref_clk_i);
      miscompares++;
      print_verdict();
   end
   initial begin
      {srst_i, wr_i, rd_i, addr_i, wdata_i} = {1'b1, 18'h0};
      repeat (16) @(posedge ref_clk_i);
      srst_i <= 1'b0;
      @(negedge ref_clk_i);
      chk({short_out_o, long_out_o, irq_o}, 8'h06);
      chk_rd(8'h01, 8'h00);
      chk_rd(8'h10, 8'h00);
      chk_rd(8'h12, 8'h00);
      chk_rd(8'h55, 8'h00);
      wr(8'h03, 8'h00);
      chk_rd(8'h03, 8'h1F);
      // ****
      // Transmit: every function against every idle output pair, counters stopped
      // ****
      for (int k = 0; k < 16; k++) begin
         wr(8'h01, {4'h4 | k[3:2], 2'b00, k[1:0]});
         settle();
         chk({short_out_o, long_out_o}, {6'h0, ~k[1], ~k[0]});
         case (k[3:2])
            0: e = !k[1] & !k[0];
            1: e = !k[1] | !k[0];
            2: e = k[1] & k[0];
            default: e = k[1] | k[0];
         endcase
         chk(combined_pin_o, e);
      end
      wr(8'h01, 8'h02);
      settle();
      chk(combined_pin_o, 8'h00);
      wr(8'h10, 8'h03);
      settle();
      chk({short_out_o, long_out_o}, 8'h02);
      tmoe_far_model_inst.pulse_tc(1'b0);
      tmoe_far_model_inst.pulse_tc(1'b1);
      settle();
      chk({short_out_o, long_out_o}, 8'h01);
      wr(8'h10, 8'h00);
      wr(8'h01, 8'h0D);
      settle();
      chk(long_out_o, 8'h01);
      wr(8'h01, 8'h08);
      settle();
      chk(long_out_o, 8'h00);
      wr(8'h01, 8'h00);
      settle();
      chk(long_out_o, 8'h01);
      // Alternating hand-over, then normal stops it
      wr(8'h01, 8'h04);
      wr(8'h10, 8'h01);
      settle();
      tmoe_far_model_inst.pulse_tc(1'b0);
      settle();
      chk({long_run_o, short_run_o}, 8'h02);
      tmoe_far_model_inst.pulse_tc(1'b1);
      settle();
      chk({long_run_o, short_run_o}, 8'h01);
      wr(8'h01, 8'h00);
      settle();
      tmoe_far_model_inst.pulse_tc(1'b0);
      settle();
      chk({long_run_o, short_run_o}, 8'h01);
      wr(8'h10, 8'h00);
      // ****
      // Demodulation: edge select, flags, interrupt, glitch filter
      // ****
      wr(8'h12, 8'h03);
      wr(8'h01, 8'h90);
      tmoe_far_model_inst.drive_wave(1'b1, 20);
      tmoe_far_model_inst.drive_wave(1'b0, 20);
      chk({n_rise[3:0], n_fall[3:0]}, 8'h10);
      chk(irq_o, 8'h01);
      chk_rd(8'h01, 8'h92);
      chk_rd(8'h11, 8'h01);
      settle();
      chk(irq_o, 8'h00);
      wr(8'h01, 8'h92);
      chk_rd(8'h01, 8'h90);
      wr(8'h01, 8'h80);
      tmoe_far_model_inst.drive_wave(1'b1, 20);
      tmoe_far_model_inst.drive_wave(1'b0, 20);
      chk({n_rise[3:0], n_fall[3:0]}, 8'h11);
      chk_rd(8'h01, 8'h81);
      wr(8'h01, 8'h81);
      chk_rd(8'h01, 8'h80);
      chk_rd(8'h11, 8'h02);
      wr(8'h12, 8'h00);
      wr(8'h01, 8'hAC);
      tmoe_far_model_inst.drive_wave(1'b1, 5);
      tmoe_far_model_inst.drive_wave(1'b0, 20);
      chk({n_rise[3:0], n_fall[3:0]}, 8'h11);
      tmoe_far_model_inst.drive_wave(1'b1, 20);
      tmoe_far_model_inst.drive_wave(1'b0, 20);
      chk({n_rise[3:0], n_fall[3:0]}, 8'h22);
      chk(irq_o, 8'h00);
      chk_rd(8'h11, 8'h03);
      print_verdict();
   end
endmodule
